// ### design/prd_top.sv
`timescale 1ns/1ns
// Overview of operation
// - A selected interval gets its pulse lengthened by exactly one clock, base width unchanged.
// - Fine code 0001 picks interval 8, 0010 picks 4 and 12, 0100 picks 2,6,10,14, 1000 all odd ones.
// - Fine bits add up as a union of intervals and interval zero is never extended.
// - Weight and fine both zero keep the non-inverted output low all the time.
// - Full weight with all fine bits gives high in intervals 1 to 15 and one low clock in interval 0.
// - Weight and fine zero with inversion set drive the output steadily high.
// - Bit 7 of every pulse width register reads one and each resets to 80h.
// - Inversion bit 6 clear drives high during the pulse, set drives low during it.
// - Bits 5 to 0 of a pulse width register are the weight compared to the low counter bits.
// - Each fine register holds the odd channel in its upper nibble, the even one below, reset zero.
// - Weight is the upper six and fine the lower four bits of one ten-bit level.
// - One shared ten-bit counter steps every clock and never stops.
// - When the low six counter bits wrap to zero every active channel starts its pulse.
// - When the low six bits equal a channel's weight its pulse ends.
// - After reset every output pin is driven low.
module prd_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [3:0] DAC_OUT
);

   // ------------------------------------------------------------
   // Channel settings and shared counter
   // ------------------------------------------------------------
   logic [9:0] count;
   logic [5:0] weight [prd_pkg::CHANNELS];
   logic invert [prd_pkg::CHANNELS];
   logic [3:0] fine [prd_pkg::CHANNELS];

   // ------------------------------------------------------------
   // Bus slave state
   // ------------------------------------------------------------
   logic aw_held;
   logic [9:0] aw_idx;
   logic w_held;
   logic [7:0] w_byte;
   logic w_lane;
   logic do_write;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic is_pw(input logic [9:0] idx);
      is_pw = (idx == prd_pkg::IDX_PW0) || (idx == prd_pkg::IDX_PW1)
           || (idx == prd_pkg::IDX_PW2) || (idx == prd_pkg::IDX_PW3);
   endfunction

   function automatic logic is_mapped(input logic [9:0] idx);
      is_mapped = is_pw(idx) || (idx == prd_pkg::IDX_FR10)
               || (idx == prd_pkg::IDX_FR32) || (idx == prd_pkg::IDX_COUNT);
   endfunction

   // Pulse width byte with the fixed top bit
   function automatic logic [7:0] pw_byte(input logic inv, input logic [5:0] w);
      pw_byte = {prd_pkg::PW_FIXED_ONE, inv, w};
   endfunction

   function automatic logic [31:0] rd_value(input logic [9:0] idx);
      rd_value = 32'h0000_0000;
      unique case (idx)
         prd_pkg::IDX_PW0: begin
            rd_value[7:0] = pw_byte(invert[0], weight[0]);
         end
         prd_pkg::IDX_PW1: begin
            rd_value[7:0] = pw_byte(invert[1], weight[1]);
         end
         prd_pkg::IDX_PW2: begin
            rd_value[7:0] = pw_byte(invert[2], weight[2]);
         end
         prd_pkg::IDX_PW3: begin
            rd_value[7:0] = pw_byte(invert[3], weight[3]);
         end
         prd_pkg::IDX_FR10: begin
            rd_value[7:0] = {fine[1], fine[0]};
         end
         prd_pkg::IDX_FR32: begin
            rd_value[7:0] = {fine[3], fine[2]};
         end
         prd_pkg::IDX_COUNT: begin
            rd_value[9:0] = count;
         end
         default: begin
            rd_value = 32'h0000_0000;
         end
      endcase
   endfunction

   // ------------------------------------------------------------
   // Shared free-running counter
   // ------------------------------------------------------------
   // Never gated, so all channels stay phase locked
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         count <= 10'h000;
      end else begin
         count <= count + 10'h001;
      end
   end

   // ------------------------------------------------------------
   // Write address channel
   // ------------------------------------------------------------
   // Address parked until data also arrives; either may come first
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_AWREADY <= 1'b0;
         aw_held <= 1'b0;
         aw_idx <= 10'h000;
      end else if (S_AXI_AWREADY && S_AXI_AWVALID) begin
         S_AXI_AWREADY <= 1'b0;
         aw_held <= 1'b1;
         aw_idx <= S_AXI_AWADDR[11:2];
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held) begin
         S_AXI_AWREADY <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Write data channel
   // ------------------------------------------------------------
   // Only byte lane 0 carries register data
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_WREADY <= 1'b0;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (S_AXI_WREADY && S_AXI_WVALID) begin
         S_AXI_WREADY <= 1'b0;
         w_held <= 1'b1;
         w_byte <= S_AXI_WDATA[7:0];
         w_lane <= S_AXI_WSTRB[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held) begin
         S_AXI_WREADY <= 1'b1;
      end
   end

   // Commit once both halves are in and the last answer is gone
   assign do_write = aw_held & w_held & ~S_AXI_BVALID;

   // ------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= prd_pkg::RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= is_mapped(aw_idx) ? prd_pkg::RESP_OKAY : prd_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   // Written bit 7 of a pulse width register is dropped; counter index is read only
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < prd_pkg::CHANNELS; i++) begin
            weight[i] <= prd_pkg::WEIGHT_RESET;
            invert[i] <= prd_pkg::INV_RESET;
            fine[i] <= prd_pkg::FINE_RESET;
         end
      end else if (do_write && w_lane) begin
         unique case (aw_idx)
            prd_pkg::IDX_PW0: begin
               invert[0] <= w_byte[prd_pkg::PW_INV_BIT];
               weight[0] <= w_byte[5:0];
            end
            prd_pkg::IDX_PW1: begin
               invert[1] <= w_byte[prd_pkg::PW_INV_BIT];
               weight[1] <= w_byte[5:0];
            end
            prd_pkg::IDX_PW2: begin
               invert[2] <= w_byte[prd_pkg::PW_INV_BIT];
               weight[2] <= w_byte[5:0];
            end
            prd_pkg::IDX_PW3: begin
               invert[3] <= w_byte[prd_pkg::PW_INV_BIT];
               weight[3] <= w_byte[5:0];
            end
            prd_pkg::IDX_FR10: begin
               fine[1] <= w_byte[7:prd_pkg::FR_HI_LSB];
               fine[0] <= w_byte[3:0];
            end
            prd_pkg::IDX_FR32: begin
               fine[3] <= w_byte[7:prd_pkg::FR_HI_LSB];
               fine[2] <= w_byte[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   // Data sampled at address accept; one read in flight at a time
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= prd_pkg::RESP_OKAY;
      end else if (S_AXI_ARREADY && S_AXI_ARVALID) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_value(S_AXI_ARADDR[11:2]);
         S_AXI_RRESP <= is_mapped(S_AXI_ARADDR[11:2]) ? prd_pkg::RESP_OKAY : prd_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end else if (!S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   // Weight above fine forms the ten-bit level per channel
   for (genvar g = 0; g < prd_pkg::CHANNELS; g++) begin : gen_chan
      prd_chan_if cif ();

      assign cif.count = count;
      assign cif.weight = weight[g];
      assign cif.fine = fine[g];
      assign cif.invert = invert[g];

      prd_channel u_chan (
         .clk (CLK),
         .rst_n (RST_N),
         .ch (cif.chan),
         .pin (DAC_OUT[g])
      );
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_count_step;
      @(posedge CLK) disable iff (!RST_N)
      RST_N |=> (count == $past(count) + 10'h001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step");

   property p_fixed_bit;
      @(posedge CLK) disable iff (!RST_N)
      (S_AXI_ARREADY && S_AXI_ARVALID && is_pw(S_AXI_ARADDR[11:2]))
         |=> (S_AXI_RVALID && S_AXI_RDATA[7]);
   endproperty
   a_fixed_bit: assert property (p_fixed_bit) else $error("pulse width bit 7 read zero");

   property p_wrap_iv0;
      @(posedge CLK) disable iff (!RST_N)
      (count == 10'h3FF) |=> (count[9:6] == 4'h0);
   endproperty
   a_wrap_iv0: assert property (p_wrap_iv0) else $error("interval not zero after wrap");

   property p_pw_write;
      @(posedge CLK) disable iff (!RST_N)
      (do_write && w_lane && aw_idx == prd_pkg::IDX_PW0)
         |=> (weight[0] == $past(w_byte[5:0]) && invert[0] == $past(w_byte[6]));
   endproperty
   a_pw_write: assert property (p_pw_write) else $error("pulse width write lost");

   property p_fr_write;
      @(posedge CLK) disable iff (!RST_N)
      (do_write && w_lane && aw_idx == prd_pkg::IDX_FR10)
         |=> ({fine[1], fine[0]} == $past(w_byte));
   endproperty
   a_fr_write: assert property (p_fr_write) else $error("fine nibbles swapped");

   property p_unmapped;
      @(posedge CLK) disable iff (!RST_N)
      (S_AXI_ARREADY && S_AXI_ARVALID && !is_mapped(S_AXI_ARADDR[11:2]))
         |=> (S_AXI_RRESP == prd_pkg::RESP_SLVERR);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

   // No disable here: the pins must sit low while reset is held
   property p_dac_reset;
      @(posedge CLK)
      !RST_N |=> (DAC_OUT == 4'h0);
   endproperty
   a_dac_reset: assert property (p_dac_reset) else $error("pins not low in reset");

   property p_fr32_write;
      @(posedge CLK) disable iff (!RST_N)
      (do_write && w_lane && aw_idx == prd_pkg::IDX_FR32)
         |=> ({fine[3], fine[2]} == $past(w_byte));
   endproperty
   a_fr32_write: assert property (p_fr32_write) else $error("upper fine nibbles swapped");

   property p_pw3_write;
      @(posedge CLK) disable iff (!RST_N)
      (do_write && w_lane && aw_idx == prd_pkg::IDX_PW3)
         |=> (weight[3] == $past(w_byte[5:0]) && invert[3] == $past(w_byte[prd_pkg::PW_INV_BIT]));
   endproperty
   a_pw3_write: assert property (p_pw3_write) else $error("channel 3 width write lost");

   // A parked address must not let a second one in
   property p_aw_held;
      @(posedge CLK) disable iff (!RST_N)
      aw_held |-> !S_AXI_AWREADY;
   endproperty
   a_aw_held: assert property (p_aw_held) else $error("address accepted while one is parked");

   // Lane 0 off means the register keeps its contents
   property p_strb_ignore;
      @(posedge CLK) disable iff (!RST_N)
      (do_write && !w_lane && aw_idx == prd_pkg::IDX_FR10)
         |=> ({fine[1], fine[0]} == $past({fine[1], fine[0]}));
   endproperty
   a_strb_ignore: assert property (p_strb_ignore) else $error("masked write changed fine values");

endmodule

// ### shared/prd_pkg.sv
package prd_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int CHANNELS = 4;
   localparam int CNT_W = 10;
   localparam int PHASE_W = 6;
   localparam int FINE_W = 4;
   localparam int ADDR_W = 12;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_PW0 = 10'h074;
   localparam logic [9:0] IDX_FR10 = 10'h075;
   localparam logic [9:0] IDX_PW1 = 10'h076;
   localparam logic [9:0] IDX_PW2 = 10'h077;
   localparam logic [9:0] IDX_FR32 = 10'h078;
   localparam logic [9:0] IDX_PW3 = 10'h079;
   localparam logic [9:0] IDX_COUNT = 10'h07A;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] PW_RESET = 8'h80;
   localparam logic [7:0] FR_RESET = 8'h00;
   localparam int PW_INV_BIT = 6;
   localparam int FR_HI_LSB = 4;
   localparam logic PW_FIXED_ONE = 1'h1;
   localparam logic INV_RESET = PW_RESET[PW_INV_BIT];
   localparam logic [5:0] WEIGHT_RESET = PW_RESET[5:0];
   localparam logic [3:0] FINE_RESET = FR_RESET[3:0];

   // ------------------------------------------------------------
   // Counter and fine interval decode
   // ------------------------------------------------------------
   localparam logic [5:0] PHASE_MAX = 6'h3F;
   localparam logic [3:0] FINE_ALL = 4'hF;
   localparam logic [3:0] IV_SEL_B0 = 4'h8;
   localparam logic [2:0] IV_SEL_B1 = 3'h4;
   localparam logic [1:0] IV_SEL_B2 = 2'h2;

   // ------------------------------------------------------------
   // Bus responses
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### shared/prd_chan_if.sv
`timescale 1ns/1ns
// Settings and shared counter handed to one channel
interface prd_chan_if;
   logic [9:0] count;
   logic [5:0] weight;
   logic invert;
   logic [3:0] fine;
   modport gen (output count, output weight, output invert, output fine);
   modport chan (input count, input weight, input invert, input fine);
endinterface

// ### design/prd_channel.sv
`timescale 1ns/1ns
module prd_channel (
   input wire logic clk,
   input wire logic rst_n,
   prd_chan_if.chan ch,
   output logic pin
);

   // ------------------------------------------------------------
   // Interval and phase split of the shared counter
   // ------------------------------------------------------------
   logic [3:0] interval;
   logic [5:0] phase;
   logic fine_sel;
   logic active;
   logic next_pin;

   assign interval = ch.count[9:6];
   assign phase = ch.count[5:0];

   // Additive fine decode; interval 0 matches no term
   assign fine_sel = (ch.fine[0] & (interval == prd_pkg::IV_SEL_B0))
                   | (ch.fine[1] & (interval[2:0] == prd_pkg::IV_SEL_B1))
                   | (ch.fine[2] & (interval[1:0] == prd_pkg::IV_SEL_B2))
                   | (ch.fine[3] & interval[0]);

   // Pulse set at phase wrap, ends on weight match, one extra cycle when fine hits
   assign active = (phase < ch.weight)
                 | (fine_sel & (phase == ch.weight));

   // Polarity applied last so an idle inverted channel sits high
   assign next_pin = active ^ ch.invert;

   // ------------------------------------------------------------
   // Output flop, low from reset
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin <= 1'b0;
      end else begin
         pin <= next_pin;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_zero_low;
      (ch.weight == 6'h00 && ch.fine == 4'h0 && !ch.invert) |=> !pin;
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("idle channel not low");

   property p_full_scale;
      (ch.weight == prd_pkg::PHASE_MAX && ch.fine == prd_pkg::FINE_ALL && !ch.invert)
         |=> (pin == ($past(ch.count) != {4'h0, prd_pkg::PHASE_MAX}));
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full scale low cycle wrong");

   property p_inv_high;
      (ch.weight == 6'h00 && ch.fine == 4'h0 && ch.invert) |=> pin;
   endproperty
   a_inv_high: assert property (p_inv_high) else $error("inverted idle channel not high");

   property p_pulse_start;
      (phase == 6'h00 && ch.weight != 6'h00) |=> (pin == !$past(ch.invert));
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse not set at wrap");

   property p_pulse_end;
      (phase == ch.weight && !fine_sel) |=> (pin == $past(ch.invert));
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse not ended on match");

   // Extra cycle is active, and the cycle after it is idle again; full weight wraps into the next pulse
   property p_extend;
      (phase == ch.weight && fine_sel && ch.weight != prd_pkg::PHASE_MAX) ##1 $stable(ch.weight)
         |-> (pin != $past(ch.invert)) ##1 (pin == $past(ch.invert));
   endproperty
   a_extend: assert property (p_extend) else $error("extension not one cycle");

   property p_no_iv0;
      (interval == 4'h0) |-> !fine_sel;
   endproperty
   a_no_iv0: assert property (p_no_iv0) else $error("interval 0 extended");

   property p_code8;
      (ch.fine == 4'h1 && fine_sel) |-> (interval == prd_pkg::IV_SEL_B0);
   endproperty
   a_code8: assert property (p_code8) else $error("code 0001 hit wrong interval");

endmodule

// ### bench/prd_rc_filter.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// External RC network on each channel pin
// ------------------------------------------------------------
module prd_rc_filter (
   input wire logic clk,
   input wire logic [3:0] pin,
   output logic [11:0] level [4]
);
   // Capacitors start discharged
   initial begin
      for (int n = 0; n < 4; n++) begin
         level[n] = 12'h000;
      end
   end

   // Leaky integrator, 1/32 per clock, a time constant of half the 64-clock pulse period
   always @(posedge clk) begin
      for (int n = 0; n < 4; n++) begin
         level[n] <= 12'(int'(level[n]) + ((pin[n] ? 4095 : 0) - int'(level[n])) / 32);
      end
   end
endmodule

// ### bench/pwm_rate_multiplier_dac_test.sv
`timescale 1ns/1ns
module pwm_rate_multiplier_dac_test;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] dac;
   logic [11:0] lvl [4];
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] rm [6];
   int mcnt = 0;
   logic [3:0] exp_out = 4'h0;
   logic pend = 1'h0, bseen = 1'h0;
   logic [11:0] p_addr;
   logic [7:0] p_data;
   logic [3:0] p_strb;
   localparam int PWI [4] = '{0, 2, 3, 5};

   prd_top prd_top_i (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DAC_OUT(dac));
   prd_rc_filter prd_rc_filter_i (.clk(clk), .pin(dac), .level(lvl));

   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   function automatic logic chan_level(int c, logic [7:0] pw, logic [3:0] f);
      int ph, iv;
      logic sel;
      ph = c % 64;
      iv = c / 64;
      sel = (f[0] && iv == 8) || (f[1] && iv % 8 == 4) || (f[2] && iv % 4 == 2) || (f[3] && iv % 2 == 1);
      return ((ph < int'(pw[5:0])) || (sel && ph == int'(pw[5:0]))) ^ pw[6];
   endfunction

   function automatic logic [3:0] fine_of(int n);
      return n % 2 ? rm[n < 2 ? 1 : 4][7:4] : rm[n < 2 ? 1 : 4][3:0];
   endfunction

   function automatic logic [11:0] addr_of(int k);
      return {prd_pkg::IDX_PW0 + 10'(k), 2'h0};
   endfunction

   // Model steps half a cycle ahead so a write lands exactly when the response rises
   always @(negedge clk) begin
      check(dac === (rst_n ? exp_out : 4'h0), "channel outputs");
      if (!rst_n) begin
         for (int k = 0; k < 6; k++) begin
            rm[k] = (k == 1 || k == 4) ? prd_pkg::FR_RESET : prd_pkg::PW_RESET;
         end
         mcnt = 0;
         exp_out = 4'h0;
         bseen = 1'h0;
      end else begin
         if (bvalid === 1'h1 && !bseen && pend && p_strb[0] && p_addr[11:2] >= prd_pkg::IDX_PW0
             && p_addr[11:2] <= prd_pkg::IDX_PW3) begin
            rm[p_addr[11:2] - prd_pkg::IDX_PW0] = (p_addr[11:2] == prd_pkg::IDX_FR10
               || p_addr[11:2] == prd_pkg::IDX_FR32) ? p_data : (p_data | 8'h80);
         end
         bseen = (bvalid === 1'h1);
         for (int n = 0; n < 4; n++) begin
            exp_out[n] = chan_level(mcnt, rm[PWI[n]], fine_of(n));
         end
         mcnt = (mcnt + 1) % 1024;
      end
   end

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   // Decisions are taken at the falling edge so ready is settled; changes follow the rising edge
   task axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      logic aw_hit, w_hit, done;
      int t;
      p_addr = a;
      p_data = d;
      p_strb = s;
      pend = 1'h1;
      done = 1'h0;
      t = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= {24'h000000, d};
      wstrb <= s;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done && t < 50) begin
         @(negedge clk);
         aw_hit = awvalid && awready === 1'h1;
         w_hit = wvalid && wready === 1'h1;
         done = bvalid === 1'h1;
         if (done) check(bresp === ((a[11:2] >= prd_pkg::IDX_PW0 && a[11:2] <= prd_pkg::IDX_COUNT)
            ? prd_pkg::RESP_OKAY : prd_pkg::RESP_SLVERR), "write response");
         @(posedge clk);
         if (aw_hit) awvalid <= 1'h0;
         if (w_hit) wvalid <= 1'h0;
         if (done) bready <= 1'h0;
         t++;
      end
      if (!done) check(1'h0, "write timeout");
      pend = 1'h0;
   endtask

   task rd_chk(input int k);
      logic ar_hit, done;
      int t;
      done = 1'h0;
      t = 0;
      @(posedge clk);
      araddr <= addr_of(k);
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!done && t < 50) begin
         @(negedge clk);
         ar_hit = arvalid && arready === 1'h1;
         done = rvalid === 1'h1;
         if (done && k >= 0 && k < 6) check(rdata === {24'h000000, rm[k]} && rresp === prd_pkg::RESP_OKAY,
            "register readback");
         else if (done && k != 6) check(rdata === 32'h00000000 && rresp === prd_pkg::RESP_SLVERR, "unmapped read");
         @(posedge clk);
         if (ar_hit) arvalid <= 1'h0;
         if (done) rready <= 1'h0;
         t++;
      end
      if (!done) check(1'h0, "read timeout");
   endtask

   // Updates one channel, keeping the partner nibble of the shared fine register
   task set_ch(input int n, input logic [7:0] pw, input logic [3:0] f);
      axi_write(addr_of(PWI[n]), pw, 4'h1);
      axi_write(addr_of(n < 2 ? 1 : 4), n % 2 ? {f, rm[n < 2 ? 1 : 4][3:0]} : {rm[n < 2 ? 1 : 4][7:4], f}, 4'h1);
   endtask

   task summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   // Roughly 10000 cycles expected; allow about three times that
   initial begin
      #300000;
      n_mismatch++;
      summarize;
   end

   initial begin
      void'($urandom(75608));
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      for (int k = 0; k < 6; k++) rd_chk(k);
      rd_chk(-80);
      axi_write(addr_of(0), 8'h3F, 4'h1);
      rd_chk(0);
      axi_write(12'h040, 8'h55, 4'h1);
      axi_write(addr_of(1), 8'hFF, 4'h0);
      axi_write(addr_of(6), 8'h12, 4'h1);
      rd_chk(1);
      // Constant, full-scale and one mid-scale setting across one whole counter period
      set_ch(0, 8'h00, 4'h0);
      set_ch(1, 8'h3F, 4'hF);
      set_ch(2, 8'h40, 4'h0);
      set_ch(3, 8'h18, 4'h6);
      repeat (1100) @(posedge clk);
      check(lvl[0] < 12'h020 && lvl[1] > 12'hF00 && lvl[2] > 12'hF00, "filtered levels");
      // Each fine code alone, with weight zero on channel 3 as the edge case
      for (int i = 0; i < 4; i++) begin
         set_ch(0, {2'h0, 6'(1 + $urandom % 62)}, 4'h1 << i);
         set_ch(3, 8'h00, 4'h1 << i);
         repeat (1030) @(posedge clk);
      end
      // Random settings on all channels, then read everything back
      for (int r = 0; r < 4; r++) begin
         for (int n = 0; n < 4; n++) set_ch(n, 8'($urandom), 4'($urandom));
         repeat (1030) @(posedge clk);
         for (int k = 0; k < 6; k++) rd_chk(k);
      end
      // Second reset in mid-run restores every register
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      for (int k = 0; k < 6; k++) rd_chk(k);
      repeat (200) @(posedge clk);
      summarize;
   end
endmodule
